// ==== hdl/pst_pkg.sv ====
package pst_pkg;

  // Block dimensions
  localparam int NUM_TIMERS = 3;
  localparam int CNT_W = 20;
  localparam int PER_W = 4;
  localparam int PHASE_W = 16;

  // Host processor byte port: enable and period registers
  localparam logic [15:0] HOST_ENABLE_ADDR = 16'hF1E6;
  localparam logic [15:0] HOST_PER_ADDR [NUM_TIMERS] =
    '{16'hF1F0, 16'hF1FA, 16'hF202};

  // Host processor byte port: count low, middle, high bytes
  localparam logic [15:0] HOST_CNTL_ADDR [NUM_TIMERS] =
    '{16'hF1F4, 16'hF1FC, 16'hF206};
  localparam logic [15:0] HOST_CNTM_ADDR [NUM_TIMERS] =
    '{16'hF1F5, 16'hF1FD, 16'hF207};
  localparam logic [15:0] HOST_CNTH_ADDR [NUM_TIMERS] =
    '{16'hF1F6, 16'hF1FE, 16'hF208};

  // Host processor byte port: mode registers
  localparam logic [15:0] HOST_MODE_ADDR [NUM_TIMERS] =
    '{16'hF1F8, 16'hF200, 16'hF20A};

  // Motion engine word port
  localparam logic [11:0] ENG_ENABLE_ADDR = 12'hEF3;
  localparam logic [11:0] ENG_PER_ADDR [NUM_TIMERS] =
    '{12'hEF8, 12'hEFD, 12'hF01};
  localparam logic [11:0] ENG_CNT_ADDR [NUM_TIMERS] =
    '{12'hEFA, 12'hEFE, 12'hF02};
  localparam logic [11:0] ENG_MODE_ADDR [NUM_TIMERS] =
    '{12'hEFC, 12'hF00, 12'hF04};

  // Reset values
  localparam logic [NUM_TIMERS-1:0] ENABLE_RST = 3'h0;
  localparam logic [PER_W-1:0] PERIOD_RST = 4'h0;
  localparam logic [CNT_W-1:0] COUNT_RST = 20'h00000;
  localparam logic [2:0] MODE_RST = 3'h0;

  // Mode register field positions
  localparam int MODE_LEVEL_BIT = 0;
  localparam int MODE_SEL_LSB = 1;
  localparam int MODE_SEL_MSB = 2;

  // Count byte lanes
  localparam int CNT_MID_LSB = 8;
  localparam int CNT_HIGH_LSB = 16;

  // Timer modes
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'b00,
    MODE_SINGLE_SHOT = 2'b01,
    MODE_SINGLE_PULSE = 2'b10,
    MODE_REPETITIVE = 2'b11
  } pst_mode_t;

  // Per-timer sequencing states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_WAIT = 2'b01,
    ST_COUNT = 2'b10,
    ST_DONE = 2'b11
  } pst_state_t;

  // Global cycle timing as seen by the timers
  typedef struct packed {
    logic global_start;
    logic sub_start;
    logic [PHASE_W-1:0] phase;
  } pst_cycle_t;

  // PWM generator timing inputs
  typedef struct packed {
    logic motor_start;
    logic [PHASE_W-1:0] motor_phase;
    logic pfc_start;
    logic [PHASE_W-1:0] pfc_phase;
    logic pfc_active;
    logic pfc_faster;
  } pst_pwm_t;

endpackage

// ==== hdl/pst_cycle_select.sv ====
module pst_cycle_select
  import pst_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire pst_pwm_t pwm, // PWM generator timing
  output pst_cycle_t cycle // Selected global cycle timing
);

  // Next global cycle timing
  pst_cycle_t cycle_d;

  // Pick the longer period as the global cycle
  always_comb begin
    if (!pwm.pfc_active) begin
      // Motor only: global cycle is the motor cycle
      cycle_d.global_start = pwm.motor_start;
      cycle_d.sub_start = pwm.motor_start;
      cycle_d.phase = pwm.motor_phase;
    end else if (pwm.pfc_faster) begin
      // Motor period is the longer one
      cycle_d.global_start = pwm.motor_start;
      cycle_d.sub_start = pwm.pfc_start;
      cycle_d.phase = pwm.pfc_phase;
    end else begin
      // Power factor period is the longer one
      cycle_d.global_start = pwm.pfc_start;
      cycle_d.sub_start = pwm.motor_start;
      cycle_d.phase = pwm.motor_phase;
    end
  end

  // Registered so every timer sees the same aligned strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle <= '0;
    end else begin
      cycle <= cycle_d;
    end
  end

endmodule

// ==== hdl/pst_timers.sv ====
// How it works
// - Motor-only system: global cycle equals motor cycle
// - Mixed rates: longer period is the global cycle
// - Three timers, each on its own fixed pin
// - Mode write arms timer, drives starting level
// - Asynchronous mode: immediate level, count ignored
// - Synchronous: count from next cycle, toggle on expiry
// - Single shot: hold level after one change
// - Single pulse: revert at cycle end, then hold
// - Repetitive: revert and restart every cycle
// - Enable bits 0..2, upper bits read zero
// - Four-bit period holds frequency ratio minus one
// - Engine sees each count as 20-bit word
// - Host sees count as three byte registers
// - Enables and periods reset to zero
// - Mode field selects one of four modes
// - Mode bit 0 gives starting pin level
// - Count scales: period nibble over 16-bit phase
module pst_timers
  import pst_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire pst_pwm_t pwm, // PWM generator cycle timing
  input wire logic host_sel, // Host byte access request
  input wire logic host_we, // Host access is a write
  input wire logic [15:0] host_addr, // Host byte address
  input wire logic [7:0] host_wdata, // Host write byte
  output logic [7:0] host_rdata, // Host read byte, next cycle
  input wire logic eng_sel, // Engine word access request
  input wire logic eng_we, // Engine access is a write
  input wire logic [11:0] eng_addr, // Engine word address
  input wire logic [CNT_W-1:0] eng_wdata, // Engine write word
  output logic [CNT_W-1:0] eng_rdata, // Engine read word, next cycle
  output logic port1_bit0_pin, // Timer 1 pin level
  output logic port2_bit7_pin, // Timer 2 pin level
  output logic port3_bit1_pin // Timer 3 pin level
);

  // Write strobes per port
  logic host_wr;
  logic eng_wr;

  // Shared enable register
  logic [NUM_TIMERS-1:0] timer_enable_reg_q;

  // Per-timer registers
  logic [PER_W-1:0] period_q [NUM_TIMERS];
  logic [CNT_W-1:0] count_q [NUM_TIMERS];
  logic [2:0] mode_q [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] arm_q;

  // Per-timer sequencing
  pst_state_t state_q [NUM_TIMERS];
  logic [PER_W-1:0] sub_idx_q [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] pin_q;

  // Read data next values
  // Decoded every clock, captured only on a read
  logic [7:0] host_rdata_d;
  logic [CNT_W-1:0] eng_rdata_d;

  // Selected global cycle timing
  // Strobes and phase run one clock behind the generator
  pst_cycle_t cycle;

  // A write needs select and write together; reads change nothing
  assign host_wr = host_sel & host_we;
  assign eng_wr = eng_sel & eng_we;

  // Global cycle selection from the PWM generator
  // One register stage, so strobe and phase stay aligned
  pst_cycle_select u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .pwm(pwm),
    .cycle(cycle)
  );

  // Enable register; engine wins a same-cycle clash
  // Only the implemented bits are stored, so the rest read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_enable_reg_q <= ENABLE_RST;
    end else if (eng_wr && eng_addr == ENG_ENABLE_ADDR) begin
      timer_enable_reg_q <= eng_wdata[NUM_TIMERS-1:0];
    end else if (host_wr && host_addr == HOST_ENABLE_ADDR) begin
      timer_enable_reg_q <= host_wdata[NUM_TIMERS-1:0];
    end
  end

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer

    // Position within the global cycle
    logic [CNT_W-1:0] pos;
    // Count reached in this cycle
    logic hit;
    // Active mode of this timer
    pst_mode_t mode;
    // Mode register write from either port
    logic mode_wr;

    // Short-cycle index on top, phase of that short cycle below
    assign pos = {sub_idx_q[i], cycle.phase};
    // Threshold compare, since the phase moves in steps
    assign hit = pos >= count_q[i];
    assign mode = pst_mode_t'(mode_q[i][MODE_SEL_MSB:MODE_SEL_LSB]);
    assign mode_wr = (eng_wr && eng_addr == ENG_MODE_ADDR[i]) ||
                     (host_wr && host_addr == HOST_MODE_ADDR[i]);

    // Period register, low nibble only
    // Upper bits are dropped so they read back as zero
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        period_q[i] <= PERIOD_RST;
      end else if (eng_wr && eng_addr == ENG_PER_ADDR[i]) begin
        period_q[i] <= eng_wdata[PER_W-1:0];
      end else if (host_wr && host_addr == HOST_PER_ADDR[i]) begin
        period_q[i] <= host_wdata[PER_W-1:0];
      end
    end

    // Count register, whole word or one byte lane
    // Engine writes the word at once; host one byte per access
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        count_q[i] <= COUNT_RST;
      end else if (eng_wr && eng_addr == ENG_CNT_ADDR[i]) begin
        count_q[i] <= eng_wdata;
      end else if (host_wr) begin
        // Byte lanes; a half-written count may fire early
        if (host_addr == HOST_CNTL_ADDR[i]) begin
          count_q[i][CNT_MID_LSB-1:0] <= host_wdata;
        end
        if (host_addr == HOST_CNTM_ADDR[i]) begin
          count_q[i][CNT_HIGH_LSB-1:CNT_MID_LSB] <= host_wdata;
        end
        if (host_addr == HOST_CNTH_ADDR[i]) begin
          count_q[i][CNT_W-1:CNT_HIGH_LSB] <= host_wdata[3:0];
        end
      end
    end

    // Mode register and its one-cycle arm pulse
    // Arm pulses even if disabled; the sequencer then drops it
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mode_q[i] <= MODE_RST;
        arm_q[i] <= 1'b0;
      end else begin
        // Arm lands after the register holds the new mode
        arm_q[i] <= mode_wr;
        if (eng_wr && eng_addr == ENG_MODE_ADDR[i]) begin
          mode_q[i] <= eng_wdata[2:0];
        end else if (host_wr && host_addr == HOST_MODE_ADDR[i]) begin
          mode_q[i] <= host_wdata[2:0];
        end
      end
    end

    // Short-cycle index inside the global cycle
    // Global start wins over a short start in the same clock
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sub_idx_q[i] <= '0;
      end else if (cycle.global_start) begin
        sub_idx_q[i] <= '0;
      end else if (cycle.sub_start && sub_idx_q[i] < period_q[i]) begin
        // Saturate at the period so counts above pFFFF never fire
        sub_idx_q[i] <= sub_idx_q[i] + 4'h1;
      end
    end

    // Pin sequencing per mode
    // Arm outranks the state walk so a rewrite restarts an enabled timer
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        state_q[i] <= ST_HOLD;
        pin_q[i] <= 1'b0;
      end else if (!timer_enable_reg_q[i]) begin
        // Disabled: frozen, pin keeps its level, arms dropped
        state_q[i] <= state_q[i];
      end else if (arm_q[i]) begin
        // Every mode drives the starting level at arm
        pin_q[i] <= mode_q[i][MODE_LEVEL_BIT];
        // Asynchronous: the level is the whole job, count unused
        if (mode == MODE_ASYNC) begin
          state_q[i] <= ST_HOLD;
        end else begin
          state_q[i] <= ST_WAIT;
        end
      end else begin
        unique case (state_q[i])
          ST_HOLD: begin
            // Idle until the mode is written again
            state_q[i] <= ST_HOLD;
          end
          ST_WAIT: begin
            // Counting starts with the next global cycle
            if (cycle.global_start) begin
              state_q[i] <= ST_COUNT;
            end
          end
          ST_COUNT: begin
            // The start cycle never fires, so count zero lands one
            // clock after the cycle begins
            if (cycle.global_start) begin
              // Cycle ended without expiry
              if (mode != MODE_REPETITIVE) begin
                state_q[i] <= ST_HOLD;
              end
            end else if (hit) begin
              // Expiry inside this cycle: one level change
              pin_q[i] <= ~pin_q[i];
              if (mode == MODE_SINGLE_SHOT) begin
                state_q[i] <= ST_HOLD;
              end else begin
                // Pulse and repetitive wait for the cycle end
                state_q[i] <= ST_DONE;
              end
            end
          end
          ST_DONE: begin
            // Cycle end restores the starting level
            if (cycle.global_start) begin
              pin_q[i] <= mode_q[i][MODE_LEVEL_BIT];
              if (mode == MODE_REPETITIVE) begin
                // Repetitive counts again from the new cycle start
                state_q[i] <= ST_COUNT;
              end else begin
                state_q[i] <= ST_HOLD;
              end
            end
          end
        endcase
      end
    end
  end

  // Read decode for both ports; unmapped reads give zero
  // Addresses never overlap, so match order does not matter
  always_comb begin
    host_rdata_d = 8'h00;
    eng_rdata_d = 20'h00000;
    if (host_addr == HOST_ENABLE_ADDR) begin
      host_rdata_d = {5'h00, timer_enable_reg_q};
    end
    if (eng_addr == ENG_ENABLE_ADDR) begin
      eng_rdata_d = {17'h00000, timer_enable_reg_q};
    end
    for (int k = 0; k < NUM_TIMERS; k++) begin
      if (host_addr == HOST_PER_ADDR[k]) begin
        host_rdata_d = {4'h0, period_q[k]};
      end
      if (host_addr == HOST_CNTL_ADDR[k]) begin
        host_rdata_d = count_q[k][CNT_MID_LSB-1:0];
      end
      if (host_addr == HOST_CNTM_ADDR[k]) begin
        host_rdata_d = count_q[k][CNT_HIGH_LSB-1:CNT_MID_LSB];
      end
      if (host_addr == HOST_CNTH_ADDR[k]) begin
        host_rdata_d = {4'h0, count_q[k][CNT_W-1:CNT_HIGH_LSB]};
      end
      if (host_addr == HOST_MODE_ADDR[k]) begin
        host_rdata_d = {5'h00, mode_q[k]};
      end
      if (eng_addr == ENG_PER_ADDR[k]) begin
        eng_rdata_d = {16'h0000, period_q[k]};
      end
      if (eng_addr == ENG_CNT_ADDR[k]) begin
        eng_rdata_d = count_q[k];
      end
      if (eng_addr == ENG_MODE_ADDR[k]) begin
        eng_rdata_d = {17'h00000, mode_q[k]};
      end
    end
  end

  // Registered read data, captured on a read request
  // Data hold between reads so a slow master may sample late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
      eng_rdata <= 20'h00000;
    end else begin
      if (host_sel && !host_we) begin
        host_rdata <= host_rdata_d;
      end
      if (eng_sel && !eng_we) begin
        eng_rdata <= eng_rdata_d;
      end
    end
  end

  // Fixed pin per timer, straight from the level flops
  // Pin direction is set by software; these carry level only
  always_comb begin
    port1_bit0_pin = pin_q[0];
    port2_bit7_pin = pin_q[1];
    port3_bit1_pin = pin_q[2];
  end

endmodule

// ==== test/pst_pwm_model.sv ====
module pst_pwm_model
  import pst_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic pfc_on, // Second stage present
  input wire logic pfc_fast, // Second stage is the faster one
  output pst_pwm_t pwm // Cycle timing
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] tick_q; // Slow cycle position, 64 clocks
  logic [15:0] slow_ph; // Slow cycle phase
  logic [15:0] fast_ph; // Fast cycle phase

  // Free-running position; fast cycle is half, so the ratio is 2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 6'h00;
    end else begin
      tick_q <= tick_q + 6'h01;
    end
  end
  assign slow_ph = {tick_q, 10'h000};
  assign fast_ph = {tick_q[4:0], 11'h000};

  // Route slow and fast cycles to the two stages
  always_comb begin
    pwm.pfc_active = pfc_on;
    pwm.pfc_faster = pfc_fast;
    pwm.motor_start = (pfc_on && !pfc_fast) ? tick_q[4:0] == 5'h00
                                            : tick_q == 6'h00;
    pwm.motor_phase = (pfc_on && !pfc_fast) ? fast_ph : slow_ph;
    pwm.pfc_start = pfc_fast ? tick_q[4:0] == 5'h00 : tick_q == 6'h00;
    pwm.pfc_phase = pfc_fast ? fast_ph : slow_ph;
    // Absent stage: lines toggle each clock, never to be trusted
    if (!pfc_on) begin
      pwm.pfc_start = tick_q[0];
      pwm.pfc_phase = {16{tick_q[0]}};
    end
  end
endmodule

// ==== test/pst_timers_assertions.sv ====
module pst_timers_assertions
  import pst_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic host_sel, // Host request
  input wire logic host_we, // Host write
  input wire logic [15:0] host_addr, // Host address
  input wire logic [7:0] host_wdata, // Host data
  input wire logic [7:0] host_rdata, // Host read data
  input wire logic eng_sel, // Engine request
  input wire logic eng_we, // Engine write
  input wire logic [11:0] eng_addr, // Engine address
  input wire logic [CNT_W-1:0] eng_wdata, // Engine data
  input wire logic [CNT_W-1:0] eng_rdata, // Engine read data
  input wire logic port1_bit0_pin, // Pin 1
  input wire logic port2_bit7_pin, // Pin 2
  input wire logic port3_bit1_pin // Pin 3
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] en_q; // Enables as last written
  logic hwr; // Host write
  logic ewr; // Engine write
  logic hrd; // Host read
  assign hwr = host_sel && host_we;
  assign ewr = eng_sel && eng_we;
  assign hrd = host_sel && !host_we;

  // Shadow of the enables; engine wins a clash
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 3'h0;
    end else if (ewr && eng_addr == ENG_ENABLE_ADDR) begin
      en_q <= eng_wdata[2:0];
    end else if (hwr && host_addr == HOST_ENABLE_ADDR) begin
      en_q <= host_wdata[2:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_host_start_level: assert property (
    hwr && host_addr == HOST_MODE_ADDR[0] && en_q[0]
    |-> ##2 port1_bit0_pin == $past(host_wdata[0], 2))
    else $error("pin 1 missed its start level");
  a_eng_start_level: assert property (
    ewr && eng_addr == ENG_MODE_ADDR[1] && en_q[1]
    |-> ##2 port2_bit7_pin == $past(eng_wdata[0], 2))
    else $error("pin 2 missed its start level");
  a_async_steady: assert property (
    hwr && host_addr == HOST_MODE_ADDR[2] && host_wdata[2:1] == 2'h0
    && en_q[2] |-> ##3 $stable(port3_bit1_pin) [*6])
    else $error("pin 3 moved in asynchronous mode");
  a_frozen_pin: assert property (
    $changed(port1_bit0_pin) |-> $past(en_q[0]))
    else $error("pin 1 moved while disabled");
  a_enable_upper: assert property (
    hrd && host_addr == HOST_ENABLE_ADDR |=> host_rdata[7:3] == 5'h00)
    else $error("enable upper bits not zero");
  a_period_upper: assert property (
    hrd && host_addr == HOST_PER_ADDR[1] |=> host_rdata[7:4] == 4'h0)
    else $error("period upper bits not zero");
  a_count_high: assert property (
    hrd && host_addr == HOST_CNTH_ADDR[0] |=> host_rdata[7:4] == 4'h0)
    else $error("count high byte upper bits not zero");
  a_eng_count_rw: assert property (
    ewr && eng_addr == ENG_CNT_ADDR[1] ##2
    eng_sel && !eng_we && eng_addr == ENG_CNT_ADDR[1]
    |=> eng_rdata == $past(eng_wdata, 3))
    else $error("engine count read back wrong");

  // Main scenarios reached
  c_repeat_mode: cover property (hwr && host_wdata[2:1] == 2'h3);
  c_pin3_rise: cover property ($rose(port3_bit1_pin));
  c_pin2_fall: cover property ($fell(port2_bit7_pin));
endmodule

bind pst_timers pst_timers_assertions u_chk (.clk, .rst_n, .host_sel,
  .host_we, .host_addr, .host_wdata, .host_rdata, .eng_sel, .eng_we,
  .eng_addr, .eng_wdata, .eng_rdata, .port1_bit0_pin, .port2_bit7_pin,
  .port3_bit1_pin);

// ==== test/tb_pst_timers.sv ====
module tb_pst_timers;
  import pst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic H = 1'h0; // Host port
  localparam logic E = 1'h1; // Engine port
  logic clk, rst_n, host_sel, host_we, eng_sel, eng_we; // Controls
  logic pfc_on, pfc_fast; // Partner setup
  logic [15:0] host_addr; // Host address
  logic [7:0] host_wdata, host_rdata; // Host data
  logic [11:0] eng_addr; // Engine address
  logic [CNT_W-1:0] eng_wdata, eng_rdata, cnt_v; // Engine data
  logic [2:0] pin, last_q; // Pins now and last seen
  logic hp, ep; // Read answers due
  logic exp_pin; // Pin level due at a change
  pst_pwm_t pwm; // Cycle timing
  logic [7:0] hq[$]; // Expected host reads
  logic [CNT_W-1:0] eq[$]; // Expected engine reads
  logic pq[3][$]; // Expected pin levels, per change
  int errors, check_count, seed; // Score and seed

  pst_pwm_model u_pwm (.clk, .rst_n, .pfc_on, .pfc_fast, .pwm);
  pst_timers u_dut (.clk, .rst_n, .pwm, .host_sel, .host_we, .host_addr,
    .host_wdata, .host_rdata, .eng_sel, .eng_we, .eng_addr, .eng_wdata,
    .eng_rdata, .port1_bit0_pin(pin[0]), .port2_bit7_pin(pin[1]),
    .port3_bit1_pin(pin[2]));

  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [CNT_W-1:0] s, input logic [CNT_W-1:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // One access; a read notes its answer first
  task automatic bus(input logic e, input logic w, input logic [15:0] a,
                     input logic [CNT_W-1:0] d);
    if (!w && e) eq.push_back(d);
    if (!w && !e) hq.push_back(d[7:0]);
    @(posedge clk);
    if (e) begin
      eng_sel <= 1'h1;
      eng_we <= w;
      eng_addr <= a[11:0];
      eng_wdata <= d;
    end else begin
      host_sel <= 1'h1;
      host_we <= w;
      host_addr <= a;
      host_wdata <= d[7:0];
    end
    @(posedge clk);
    eng_sel <= 1'h0;
    host_sel <= 1'h0;
  endtask

  // Timer 2 mode via engine, others via host
  task automatic md(input int i, input logic [2:0] v);
    if (i == 1) bus(E, 1'h1, 16'(ENG_MODE_ADDR[1]), {17'h0, v});
    else bus(H, 1'h1, HOST_MODE_ADDR[i], {17'h0, v});
  endtask

  // Note n pin changes, oldest in bit 0
  task automatic note(input int i, input logic [3:0] v, input int n);
    for (int k = 0; k < n; k++) pq[i].push_back(v[k]);
  endtask

  // Wait n global starts, then 16 clocks into the cycle
  task automatic wait_g(input int n);
    repeat (n) begin
      do @(posedge clk);
      while (!((pfc_on && !pfc_fast) ? pwm.pfc_start : pwm.motor_start));
    end
    repeat (16) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Monitor: compare reads and every pin change with the oldest note
  always @(posedge clk) begin
    if (hp) chk(CNT_W'(host_rdata), CNT_W'(hq.pop_front()));
    if (ep) chk(eng_rdata, eq.pop_front());
    // No note means the pin should have kept its level; skip reset
    for (int i = 0; i < 3; i++) begin
      if (rst_n && pin[i] !== last_q[i]) begin
        exp_pin = pq[i].size() > 0 ? pq[i].pop_front() : last_q[i];
        chk(CNT_W'(pin[i]), CNT_W'(exp_pin));
      end
    end
    hp <= host_sel && !host_we;
    ep <= eng_sel && !eng_we;
    last_q <= pin;
  end

  // Hang guard, well beyond the expected run
  initial begin
    #60000;
    errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    stop_test;
  end

  initial begin
    seed = 65484;
    {rst_n, host_sel, host_we, eng_sel, eng_we, pfc_on, pfc_fast} = 7'h00;
    host_addr = 16'h0;
    host_wdata = 8'h0;
    eng_addr = 12'h0;
    eng_wdata = 20'h0;
    {hp, ep, last_q} = 5'h00;
    errors = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    // Reset values, unmapped place too
    bus(H, 1'h0, HOST_ENABLE_ADDR, 20'h0);
    bus(H, 1'h0, 16'h0, 20'h0);
    for (int i = 0; i < 3; i++) begin
      bus(H, 1'h0, HOST_PER_ADDR[i], 20'h0);
      bus(E, 1'h0, 16'(ENG_CNT_ADDR[i]), 20'h0);
    end
    $display("test reset_values done");
    // Unused bits drop; bytes and word views agree
    bus(H, 1'h1, HOST_ENABLE_ADDR, 20'hFF);
    bus(H, 1'h0, HOST_ENABLE_ADDR, 20'h07);
    for (int i = 0; i < 3; i++) begin
      cnt_v = CNT_W'($random(seed));
      bus(H, 1'h1, HOST_PER_ADDR[i], cnt_v | 20'hF0);
      bus(H, 1'h0, HOST_PER_ADDR[i], {16'h0, cnt_v[3:0]});
      bus(H, 1'h1, HOST_CNTL_ADDR[i], {12'h0, cnt_v[7:0]});
      bus(H, 1'h1, HOST_CNTM_ADDR[i], {12'h0, cnt_v[15:8]});
      bus(H, 1'h1, HOST_CNTH_ADDR[i], {12'h0, 4'hF, cnt_v[19:16]});
      bus(E, 1'h0, 16'(ENG_CNT_ADDR[i]), cnt_v);
      bus(H, 1'h0, HOST_CNTH_ADDR[i], {16'h0, cnt_v[19:16]});
      bus(E, 1'h1, 16'(ENG_CNT_ADDR[i]), ~cnt_v);
      bus(E, 1'h0, 16'(ENG_CNT_ADDR[i]), ~cnt_v);
      bus(H, 1'h0, HOST_CNTM_ADDR[i], {12'h0, ~cnt_v[15:8]});
    end
    $display("test register_access done");
    // Setup first, mode last; three modes side by side
    bus(H, 1'h1, HOST_ENABLE_ADDR, 20'h07);
    for (int i = 0; i < 3; i++) begin
      bus(E, 1'h1, 16'(ENG_PER_ADDR[i]), 20'h0);
      bus(E, 1'h1, 16'(ENG_CNT_ADDR[i]), 20'h08000);
    end
    wait_g(1);
    note(0, 4'h1, 1);
    md(0, 3'h2);
    note(1, 4'h1, 2);
    md(1, 3'h4);
    note(2, 4'h5, 4);
    md(2, 3'h6);
    wait_g(3);
    $display("test sync_modes done");
    // Asynchronous levels both ways
    note(0, 4'h0, 1);
    md(0, 3'h0);
    note(1, 4'h1, 1);
    md(1, 3'h1);
    note(2, 4'h1, 1);
    md(2, 3'h1);
    repeat (12) @(posedge clk);
    note(1, 4'h0, 1);
    md(1, 3'h0);
    note(2, 4'h0, 1);
    md(2, 3'h0);
    repeat (12) @(posedge clk);
    $display("test async_mode done");
    // Two rates, ratio 2: global cycle is the slower
    for (int k = 0; k < 2; k++) begin
      pfc_on <= 1'h1;
      pfc_fast <= k[0];
      bus(H, 1'h1, HOST_PER_ADDR[2], 20'h1);
      bus(E, 1'h1, 16'(ENG_CNT_ADDR[2]), 20'h18000);
      wait_g(1);
      note(2, 4'h5, 4);
      md(2, 3'h6);
      wait_g(3);
      md(2, 3'h0);
    end
    $display("test two_rates done");
    // Clearing the enable freezes a repeating pin low
    pfc_on <= 1'h0;
    wait_g(1);
    note(0, 4'h1, 2);
    md(0, 3'h7);
    wait_g(1);
    repeat (24) @(posedge clk);
    bus(H, 1'h1, HOST_ENABLE_ADDR, 20'h0);
    wait_g(2);
    $display("test freeze done");
    for (int i = 0; i < 3; i++) chk(CNT_W'(pq[i].size()), 20'h0);
    stop_test;
  end
endmodule
